// *** rtl/ucr_params.svh ***
// constants for the usb control request decoder
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH
`define UCR_RT_STD_IN_EP   8'h82
`define UCR_RT_STD_DEV     8'h00
`define UCR_RT_STD_EP      8'h02
`define UCR_RT_STD_IF      8'h01
`define UCR_RT_VND_OUT     8'h40
`define UCR_RT_VND_IN      8'hc0
`define UCR_RQ_GET_STATUS  8'h00
`define UCR_RQ_SET_FEATURE 8'h03
`define UCR_RQ_SET_ADDRESS 8'h05
`define UCR_RQ_SET_CONFIG  8'h09
`define UCR_RQ_SET_IF      8'h0b
`define UCR_RQ_REG_WRITE   8'ha0
`define UCR_RQ_REG_READ    8'ha1
`define UCR_RQ_GET_STATS   8'ha2
`define UCR_EP_BULK_IN     16'h0081
`define UCR_EP_BULK_OUT    16'h0002
`define UCR_EP_INTR        16'h0083
`define UCR_FEAT_HALT      16'h0000
`define UCR_FEAT_WAKEUP    16'h0001
`define UCR_FEAT_TEST      16'h0002
`define UCR_CONFIG_ONE     16'h0001
`define UCR_LEN_STATUS     16'h0002
`define UCR_LEN_REG        16'h0004
`define UCR_LEN_RX_STATS   16'h0020
`define UCR_LEN_TX_STATS   16'h0028
`define UCR_SEL_RX         16'h0000
`define UCR_SEL_TX         16'h0001
`define UCR_RX_WORDS       4'h8
`define UCR_TX_WORDS       4'ha
`define UCR_CNT_MAX        32'hffffffff
`endif

// *** rtl/ucr_pkg.sv ***
// types shared by both ends of the control request link
`default_nettype none
package ucr_pkg;
    typedef logic [7:0]  ucr_byte_t;
    typedef logic [15:0] ucr_half_t;
    typedef logic [31:0] ucr_word_t;
    // answer codes of one request
    typedef enum logic [1:0] {
        UCR_ANS_NONE  = 2'b00,
        UCR_ANS_ACK   = 2'b01,
        UCR_ANS_STALL = 2'b10
    } ucr_ans_e;
    // one setup stage
    typedef struct packed {
        ucr_byte_t req_type;
        ucr_byte_t req_code;
        ucr_half_t value;
        ucr_half_t index;
        ucr_half_t length;
    } ucr_setup_s;
endpackage
`default_nettype wire

// *** rtl/ucr_link_if.sv ***
// link joining the request issuer and the request decoder
`default_nettype none
interface ucr_link_if
    import ucr_pkg::*;
    (input wire logic clk_sys_i);
    logic       setup_valid; // one-cycle setup strobe
    ucr_setup_s setup;       // setup fields
    logic       wr_valid;    // one-cycle out data word strobe
    ucr_word_t  wr_data;     // out data stage word
    logic       busy;        // decoder working on a request
    logic       rd_valid;    // one-cycle in data word strobe
    ucr_word_t  rd_data;     // in data stage word
    logic       done;        // one-cycle answer strobe
    ucr_ans_e   answer;      // ack or stall, valid with done
    modport issuer  (output setup_valid, setup, wr_valid, wr_data,
                     input  busy, rd_valid, rd_data, done, answer);
    modport decoder (input  setup_valid, setup, wr_valid, wr_data,
                     output busy, rd_valid, rd_data, done, answer);
endinterface
`default_nettype wire

// *** rtl/ucr_host.sv ***
// request issuer end: sends one setup stage and collects the answer
`include "ucr_params.svh"
`default_nettype none
module ucr_host
    import ucr_pkg::*;
    (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // user command
    input  wire logic       cmd_valid_i,
    input  var  ucr_setup_s cmd_setup_i,
    input  wire ucr_word_t  cmd_wdata_i,
    output logic            cmd_ready_o,
    // user result
    output logic            res_valid_o,
    output ucr_ans_e        res_answer_o,
    output logic            res_word_valid_o,
    output ucr_word_t       res_word_o,
    // link
    ucr_link_if.issuer      link
    );
    logic      pend_r;  // request outstanding
    logic      wsend_r; // out word still to send
    ucr_word_t wdat_r;  // held out word
    // issue the setup, taken only while idle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            link.setup_valid <= 1'b0;
            link.setup       <= '0;
            pend_r           <= 1'b0;
            wsend_r          <= 1'b0;
            wdat_r           <= '0;
        end else begin
            link.setup_valid <= 1'b0;
            if (cmd_valid_i && !pend_r && !link.busy) begin
                link.setup_valid <= 1'b1;
                link.setup       <= cmd_setup_i;
                // stats lengths follow the selected block
                if (cmd_setup_i.req_code == `UCR_RQ_GET_STATS) begin
                    link.setup.length <= (cmd_setup_i.index == `UCR_SEL_TX) ?
                        `UCR_LEN_TX_STATS : `UCR_LEN_RX_STATS;
                end
                pend_r  <= 1'b1;
                wsend_r <= cmd_setup_i.req_type == `UCR_RT_VND_OUT;
                wdat_r  <= cmd_wdata_i;
            end else if (link.done) begin
                pend_r  <= 1'b0;
                wsend_r <= 1'b0;
            end else if (wsend_r) begin
                wsend_r <= 1'b0; // single word only, no bursts
            end
        end
    end
    // out data word one cycle after setup
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            link.wr_valid <= 1'b0;
            link.wr_data  <= '0;
        end else begin
            link.wr_valid <= wsend_r && !link.done;
            link.wr_data  <= wdat_r;
        end
    end
    // results straight from flops
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmd_ready_o      <= 1'b0;
            res_valid_o      <= 1'b0;
            res_answer_o     <= UCR_ANS_NONE;
            res_word_valid_o <= 1'b0;
            res_word_o       <= '0;
        end else begin
            cmd_ready_o      <= !pend_r && !link.busy && !cmd_valid_i;
            res_valid_o      <= link.done;
            res_answer_o     <= link.done ? link.answer : UCR_ANS_NONE;
            res_word_valid_o <= link.rd_valid;
            if (link.rd_valid) begin
                res_word_o <= link.rd_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/ucr_device.sv ***
// device end: decodes control requests and answers them
`include "ucr_params.svh"
`default_nettype none
module ucr_device
    import ucr_pkg::*;
    (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // link
    ucr_link_if.decoder      link,
    // power and register space
    input  wire logic        pwr_normal_i,
    input  wire logic [11:0] mac_base_i,
    output logic             csr_wr_o,
    output logic             csr_rd_o,
    output logic [11:0]      csr_addr_o,
    output ucr_word_t        csr_wdata_o,
    input  wire ucr_word_t   csr_rdata_i,
    // statistics events, one bit per counter
    input  wire logic [7:0]  rx_evt_i,
    input  wire logic [9:0]  tx_evt_i,
    // device state
    output logic [6:0]       dev_addr_o,
    output logic             configured_o,
    output logic             wakeup_en_o,
    output logic             test_mode_o,
    output logic [2:0]       ep_halt_o
    );
    // states of one request
    typedef enum logic [2:0] {
        UCR_ST_IDLE  = 3'b000,
        UCR_ST_WDATA = 3'b001,
        UCR_ST_RREG  = 3'b010,
        UCR_ST_RDATA = 3'b011,
        UCR_ST_STATS = 3'b100,
        UCR_ST_DONE  = 3'b101
    } ucr_state_e;

    ucr_state_e  state_r;        // request state
    ucr_setup_s  su_r;           // latched setup
    ucr_ans_e    ans_r;          // pending answer
    logic        sel_tx_r;       // stats block chosen
    logic [3:0]  widx_r;         // stats word index
    ucr_word_t   rx_cnt_r [8];   // receive counters
    ucr_word_t   tx_cnt_r [10];  // transmit counters
    logic [7:0]  rx_clr;         // counters read this cycle
    logic [9:0]  tx_clr;

    // saturating increment, used by both counter blocks
    function automatic ucr_word_t sat_inc(input ucr_word_t v);
        return (v == `UCR_CNT_MAX) ? v : v + 32'h00000001;
    endfunction

    // endpoint index from wIndex, 3 means none
    function automatic logic [1:0] ep_sel(input ucr_half_t idx);
        unique case (idx)
            `UCR_EP_BULK_IN:  return 2'h0;
            `UCR_EP_BULK_OUT: return 2'h1;
            `UCR_EP_INTR:     return 2'h2;
            default:          return 2'h3;
        endcase
    endfunction

    logic [1:0] ep_w;            // endpoint of incoming setup
    assign ep_w = ep_sel(link.setup.index);
    logic       reg_ok_w;        // register access allowed in this power state
    assign reg_ok_w = link.setup.length == `UCR_LEN_REG &&
                      !(pwr_normal_i && link.setup.index[11:0] >= mac_base_i);

    // request sequencing
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_r       <= UCR_ST_IDLE;
            su_r          <= '0;
            ans_r         <= UCR_ANS_NONE;
            sel_tx_r      <= 1'b0;
            widx_r        <= 4'h0;
        end else begin
            unique case (state_r)
                UCR_ST_IDLE: begin
                    if (link.setup_valid) begin
                        su_r     <= link.setup;
                        sel_tx_r <= link.setup.index == `UCR_SEL_TX;
                        widx_r   <= 4'h0;
                        state_r  <= UCR_ST_DONE;
                        ans_r    <= UCR_ANS_STALL;
                        // decode type and code together
                        unique case ({link.setup.req_type, link.setup.req_code})
                            {`UCR_RT_STD_IN_EP, `UCR_RQ_GET_STATUS}: begin
                                if (link.setup.length == `UCR_LEN_STATUS &&
                                    ep_w != 2'h3) begin
                                    ans_r   <= UCR_ANS_ACK;
                                    state_r <= UCR_ST_RDATA;
                                end
                            end
                            {`UCR_RT_STD_DEV, `UCR_RQ_SET_ADDRESS}: begin
                                if (link.setup.index == 16'h0000 &&
                                    link.setup.length == 16'h0000) begin
                                    ans_r <= UCR_ANS_ACK;
                                end
                            end
                            {`UCR_RT_STD_DEV, `UCR_RQ_SET_FEATURE}: begin
                                if (link.setup.index == 16'h0000 &&
                                    (link.setup.value == `UCR_FEAT_WAKEUP ||
                                     link.setup.value == `UCR_FEAT_TEST)) begin
                                    ans_r <= UCR_ANS_ACK;
                                end
                            end
                            {`UCR_RT_STD_EP, `UCR_RQ_SET_FEATURE}: begin
                                if (link.setup.value == `UCR_FEAT_HALT &&
                                    ep_w != 2'h3) begin
                                    ans_r <= UCR_ANS_ACK;
                                end
                            end
                            {`UCR_RT_STD_DEV, `UCR_RQ_SET_CONFIG}: begin
                                if (link.setup.value == `UCR_CONFIG_ONE) begin
                                    ans_r <= UCR_ANS_ACK;
                                end
                            end
                            {`UCR_RT_STD_IF, `UCR_RQ_SET_IF}: begin
                                if (link.setup.value == 16'h0000 &&
                                    link.setup.index == 16'h0000) begin
                                    ans_r <= UCR_ANS_ACK;
                                end
                            end
                            {`UCR_RT_VND_OUT, `UCR_RQ_REG_WRITE}: begin
                                // the data word is always sent; drop it if stalled
                                state_r <= UCR_ST_WDATA;
                                if (reg_ok_w) begin
                                    ans_r <= UCR_ANS_ACK;
                                end
                            end
                            {`UCR_RT_VND_IN, `UCR_RQ_REG_READ}: begin
                                if (reg_ok_w) begin
                                    ans_r   <= UCR_ANS_ACK;
                                    state_r <= UCR_ST_RREG;
                                end
                            end
                            {`UCR_RT_VND_IN, `UCR_RQ_GET_STATS}: begin
                                if (link.setup.index == `UCR_SEL_RX ||
                                    link.setup.index == `UCR_SEL_TX) begin
                                    ans_r   <= UCR_ANS_ACK;
                                    state_r <= UCR_ST_STATS;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                UCR_ST_WDATA: if (link.wr_valid) state_r <= UCR_ST_DONE;
                UCR_ST_RREG:  state_r <= UCR_ST_RDATA; // csr answers next cycle
                UCR_ST_RDATA: state_r <= UCR_ST_DONE;
                UCR_ST_STATS: begin
                    widx_r <= widx_r + 4'h1;
                    if (widx_r == (sel_tx_r ? `UCR_TX_WORDS : `UCR_RX_WORDS) - 4'h1) begin
                        state_r <= UCR_ST_DONE;
                    end
                end
                UCR_ST_DONE:  state_r <= UCR_ST_IDLE;
                default:      state_r <= UCR_ST_IDLE;
            endcase
        end
    end

    // link outputs, all registered
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            link.busy     <= 1'b0;
            link.rd_valid <= 1'b0;
            link.rd_data  <= '0;
            link.done     <= 1'b0;
            link.answer   <= UCR_ANS_NONE;
        end else begin
            link.busy     <= (state_r != UCR_ST_IDLE) || link.setup_valid;
            link.done     <= state_r == UCR_ST_DONE;
            link.answer   <= (state_r == UCR_ST_DONE) ? ans_r : UCR_ANS_NONE;
            link.rd_valid <= 1'b0;
            if (state_r == UCR_ST_RDATA) begin
                link.rd_valid <= 1'b1;
                if (su_r.req_code == `UCR_RQ_GET_STATUS) begin
                    link.rd_data <= {31'h00000000, ep_halt_o[ep_sel(su_r.index)]};
                end else begin
                    link.rd_data <= csr_rdata_i;
                end
            end else if (state_r == UCR_ST_STATS) begin
                link.rd_valid <= 1'b1;
                link.rd_data  <= sel_tx_r ? tx_cnt_r[widx_r] : rx_cnt_r[widx_r[2:0]];
            end
        end
    end

    // single register access strobes
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            csr_wr_o    <= 1'b0;
            csr_rd_o    <= 1'b0;
            csr_addr_o  <= 12'h000;
            csr_wdata_o <= '0;
        end else begin
            csr_wr_o <= state_r == UCR_ST_WDATA && link.wr_valid &&
                        ans_r == UCR_ANS_ACK;
            csr_rd_o <= state_r == UCR_ST_RREG;
            if (link.setup_valid && state_r == UCR_ST_IDLE) begin
                csr_addr_o <= link.setup.index[11:0];
            end
            if (link.wr_valid) begin
                csr_wdata_o <= link.wr_data;
            end
        end
    end

    // word read out this cycle is cleared
    always_comb begin
        rx_clr = 8'h00;
        tx_clr = 10'h000;
        if (state_r == UCR_ST_STATS) begin
            if (sel_tx_r) tx_clr[widx_r] = 1'b1;
            else          rx_clr[widx_r[2:0]] = 1'b1;
        end
    end

    // counters: clear on read beats a same-cycle event
    // (one lost count is cheaper than a double count)
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < 8; i++) begin
            if (!rst_n_i || rx_clr[i]) rx_cnt_r[i] <= '0;
            else if (rx_evt_i[i])      rx_cnt_r[i] <= sat_inc(rx_cnt_r[i]);
        end
        for (int j = 0; j < 10; j++) begin
            if (!rst_n_i || tx_clr[j]) tx_cnt_r[j] <= '0;
            else if (tx_evt_i[j])      tx_cnt_r[j] <= sat_inc(tx_cnt_r[j]);
        end
    end

    // device state changes on acked requests
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dev_addr_o   <= 7'h00;
            configured_o <= 1'b0;
            wakeup_en_o  <= 1'b0;
            test_mode_o  <= 1'b0;
            ep_halt_o    <= 3'b000;
        end else if (state_r == UCR_ST_DONE && ans_r == UCR_ANS_ACK) begin
            unique case (su_r.req_code)
                `UCR_RQ_SET_ADDRESS: dev_addr_o <= su_r.value[6:0];
                `UCR_RQ_SET_CONFIG:  configured_o <= 1'b1;
                `UCR_RQ_SET_FEATURE: begin
                    if (su_r.req_type == `UCR_RT_STD_EP) begin
                        ep_halt_o[ep_sel(su_r.index)] <= 1'b1;
                    end else if (su_r.value == `UCR_FEAT_WAKEUP) begin
                        wakeup_en_o <= 1'b1;
                    end else begin
                        test_mode_o <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** tb/ucr_checker.sv ***
// link checker for the control request issuer and decoder pair
`default_nettype none
module ucr_checker
    import ucr_pkg::*;
    (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    // link signals
    input wire logic       setup_valid,
    input var  ucr_setup_s setup,
    input wire logic       wr_valid,
    input wire ucr_word_t  wr_data,
    input wire logic       busy,
    input wire logic       rd_valid,
    input wire ucr_word_t  rd_data,
    input wire logic       done,
    input var  ucr_ans_e   answer
    );
    // request kind flags, only meaningful with setup_valid
    logic st_req;  // endpoint status
    logic rx_req;  // receive statistics
    logic tx_req;  // transmit statistics
    logic if_req;  // set interface
    assign st_req = setup_valid && setup.req_type == 8'h82 && setup.req_code == 8'h00
        && setup.length == 16'h0002 && setup.value == 16'h0000
        && (setup.index == 16'h0081 || setup.index == 16'h0002 || setup.index == 16'h0083);
    assign rx_req = setup_valid && setup.req_type == 8'hc0 && setup.req_code == 8'ha2
        && setup.index == 16'h0000 && setup.value == 16'h0000;
    assign tx_req = setup_valid && setup.req_type == 8'hc0 && setup.req_code == 8'ha2
        && setup.index == 16'h0001 && setup.value == 16'h0000;
    assign if_req = setup_valid && setup.req_type == 8'h01 && setup.req_code == 8'h0b;

    // single domain, so one clock and one disable for all
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_done_code: assert property ((answer != UCR_ANS_NONE) == done)
        else $error("answer code out of step with done");
    a_status_word: assert property (st_req |-> ##2 (rd_valid && rd_data[15:1] == 15'h0)
        ##1 (done && answer == UCR_ANS_ACK)) else $error("endpoint status word wrong");
    a_rx_stat_words: assert property (rx_req |-> ##2 rd_valid [*8]
        ##1 (done && !rd_valid && answer == UCR_ANS_ACK)) else $error("rx stats not 8 words");
    a_tx_stat_words: assert property (tx_req |-> ##2 rd_valid [*8] ##1 rd_valid [*2]
        ##1 (done && !rd_valid && answer == UCR_ANS_ACK)) else $error("tx stats not 10 words");
    a_set_if_code: assert property (if_req |-> ##2 done && answer ==
        (($past(setup.value, 2) == 16'h0 && $past(setup.index, 2) == 16'h0)
        ? UCR_ANS_ACK : UCR_ANS_STALL)) else $error("set interface answer wrong");
    a_config_ack: assert property (setup_valid && setup.req_code == 8'h09
        && setup.req_type == 8'h00 && setup.value == 16'h0001
        |-> ##2 done && answer == UCR_ANS_ACK) else $error("configuration one refused");
    a_address_ack: assert property (setup_valid && setup.req_code == 8'h05
        && setup.req_type == 8'h00 && setup.index == 16'h0 && setup.length == 16'h0
        |-> ##2 done && answer == UCR_ANS_ACK) else $error("set address refused");
    a_unknown_stall: assert property (setup_valid && setup.req_code == 8'h77
        |-> ##2 done && answer == UCR_ANS_STALL) else $error("unknown code not stalled");
    a_write_once: assert property (setup_valid && setup.req_type == 8'h40
        && setup.req_code == 8'ha0 |-> ##1 wr_valid ##1 !wr_valid ##[1:2] (done && !wr_valid))
        else $error("register write not a single word");
    a_busy_after: assert property (setup_valid |=> busy)
        else $error("decoder not busy after setup");
endmodule
`default_nettype wire

// *** tb/usb_control_request_decoder_tb_top.sv ***
// self-checking bench for the issuer and decoder joined by the link
`default_nettype none
module usb_control_request_decoder_tb_top
    import ucr_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0;     // core clock
    logic        rst_n_i = 1'b0;       // sync reset
    logic        cmd_valid_i = 1'b0;   // user command
    ucr_setup_s  cmd_setup_i = '0;
    ucr_word_t   cmd_wdata_i = '0;
    logic        cmd_ready_o, res_valid_o, res_word_valid_o;
    ucr_ans_e    res_answer_o;
    ucr_word_t   res_word_o;
    logic        pwr_normal_i = 1'b0;  // power state
    logic [11:0] mac_base_i = 12'h800; // mac group starts here
    logic        csr_wr_o, csr_rd_o;
    logic [11:0] csr_addr_o;
    ucr_word_t   csr_wdata_o;
    ucr_word_t   csr_rdata_i = '0;
    logic [7:0]  rx_evt_i = '0;        // counter events
    logic [9:0]  tx_evt_i = '0;
    logic [6:0]  dev_addr_o;
    logic        configured_o, wakeup_en_o, test_mode_o;
    logic [2:0]  ep_halt_o;
    int          mismatches, n_tests, n_wr, cycles;
    ucr_ans_e    got;                  // answer of last request
    ucr_word_t   words[$];             // data words of last request
    int unsigned rx_cnt[8];
    int unsigned tx_cnt[10];
    logic [11:0] wr_addr;              // last register write seen
    ucr_word_t   wr_data;
    logic [15:0] eps[3] = '{16'h0081, 16'h0002, 16'h0083};

    always #10 clk_sys_i = ~clk_sys_i;
    ucr_link_if ucr_link_if_i (.clk_sys_i(clk_sys_i));
    ucr_host ucr_host_i (.clk_sys_i, .rst_n_i, .cmd_valid_i, .cmd_setup_i, .cmd_wdata_i,
        .cmd_ready_o, .res_valid_o, .res_answer_o, .res_word_valid_o, .res_word_o,
        .link(ucr_link_if_i));
    ucr_device ucr_device_i (.clk_sys_i, .rst_n_i, .link(ucr_link_if_i), .pwr_normal_i,
        .mac_base_i, .csr_wr_o, .csr_rd_o, .csr_addr_o, .csr_wdata_o, .csr_rdata_i,
        .rx_evt_i, .tx_evt_i, .dev_addr_o, .configured_o, .wakeup_en_o, .test_mode_o,
        .ep_halt_o);
    ucr_checker ucr_checker_i (.clk_sys_i, .rst_n_i,
        .setup_valid(ucr_link_if_i.setup_valid), .setup(ucr_link_if_i.setup),
        .wr_valid(ucr_link_if_i.wr_valid), .wr_data(ucr_link_if_i.wr_data),
        .busy(ucr_link_if_i.busy), .rd_valid(ucr_link_if_i.rd_valid),
        .rd_data(ucr_link_if_i.rd_data), .done(ucr_link_if_i.done),
        .answer(ucr_link_if_i.answer));

    // register space stand-in: data depends on address so a wrong address shows
    function automatic ucr_word_t reg_val(input logic [11:0] a);
        return {a, ~a, 8'h5c};
    endfunction

    // reads answer mid-cycle, writes are logged
    always @(negedge clk_sys_i) begin
        if (csr_rd_o) csr_rdata_i <= reg_val(csr_addr_o);
        if (csr_wr_o) begin
            n_wr <= n_wr + 1;
            wr_addr <= csr_addr_o;
            wr_data <= csr_wdata_o;
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, far above the run's length
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one request: wait for ready, pulse valid, gather words until the answer
    task automatic req(input logic [7:0] t, c, input logic [15:0] v, i, l, input ucr_word_t wd);
        int k;
        words.delete();
        @(negedge clk_sys_i);
        k = 0;
        while (cmd_ready_o !== 1'b1 && k++ < 50) @(negedge clk_sys_i);
        cmd_setup_i = '{t, c, v, i, l};
        cmd_wdata_i = wd;
        cmd_valid_i = 1'b1;
        @(negedge clk_sys_i);
        cmd_valid_i = 1'b0;
        got = UCR_ANS_NONE;
        k = 0;
        while (got == UCR_ANS_NONE && k++ < 60) begin
            if (res_word_valid_o === 1'b1) words.push_back(res_word_o);
            if (res_valid_o === 1'b1) got = res_answer_o;
            else @(negedge clk_sys_i);
        end
    endtask

    // random counter events, tallied per counter
    task automatic bump(input int n);
        logic [31:0] r;
        repeat (n) begin
            @(negedge clk_sys_i);
            r = $urandom;
            rx_evt_i = r[7:0];
            tx_evt_i = r[17:8];
            for (int b = 0; b < 10; b++) begin
                if (b < 8) rx_cnt[b] += r[b];
                tx_cnt[b] += r[8+b];
            end
        end
        @(negedge clk_sys_i);
        rx_evt_i = '0;
        tx_evt_i = '0;
    endtask

    initial begin
        logic [15:0] v;
        logic [11:0] a;
        ucr_word_t   wd;
        int          n0;
        logic        ok;
        void'($urandom(97438));
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rst_n_i = 1'b1;
        chk("reset state", {dev_addr_o, configured_o, wakeup_en_o, test_mode_o, ep_halt_o}, 0);
        v = $urandom;
        req(8'h00, 8'h05, v, 0, 0, 0);
        chk("address", {got, dev_addr_o}, {UCR_ANS_ACK, v[6:0]});
        req(8'h00, 8'h09, 16'h0002, 0, 0, 0);
        chk("config two", {got, configured_o}, {UCR_ANS_STALL, 1'b0});
        req(8'h00, 8'h09, 16'h0001, 0, 0, 0);
        chk("config one", configured_o, 1'b1);
        req(8'h00, 8'h03, 16'h0001, 0, 0, 0);
        chk("wakeup", wakeup_en_o, 1'b1);
        req(8'h00, 8'h03, 16'h0002, 0, 0, 0);
        chk("test mode", test_mode_o, 1'b1);
        // each endpoint: clear status, halt it, status shows the halt
        for (int e = 0; e < 3; e++) begin
            req(8'h82, 8'h00, 0, eps[e], 16'h0002, 0);
            chk("status clear", words[0][15:0], 16'h0000);
            req(8'h02, 8'h03, 16'h0000, eps[e], 0, 0);
            chk("halt bits", {got, ep_halt_o}, {UCR_ANS_ACK, 3'b111 >> (2 - e)});
            req(8'h82, 8'h00, 0, eps[e], 16'h0002, 0);
            chk("status halted", {words.size(), words[0][15:0]}, {32'd1, 16'h0001});
        end
        req(8'h82, 8'h00, 0, 16'h0084, 16'h0002, 0);
        chk("status bad ep", got, UCR_ANS_STALL);
        for (int k = 0; k < 3; k++) begin
            req(8'h01, 8'h0b, k[0], k[1], 0, 0);
            chk("set interface", got, k == 0 ? UCR_ANS_ACK : UCR_ANS_STALL);
        end
        // register access below and above the mac boundary, both power states
        for (int p = 0; p < 2; p++) begin
            @(negedge clk_sys_i) pwr_normal_i = p[0];
            for (int m = 0; m < 2; m++) begin
                a = m ? (12'h800 | 12'($urandom)) : (12'h7ff & 12'($urandom));
                wd = $urandom;
                n0 = n_wr;
                ok = !(p && m);
                req(8'h40, 8'ha0, 0, {4'h0, a}, 16'h0004, wd);
                chk("write answer", got, ok ? UCR_ANS_ACK : UCR_ANS_STALL);
                chk("write count", n_wr - n0, ok);
                if (ok) chk("write addr", wr_addr, a);
                if (ok) chk("write data", wr_data, wd);
                req(8'hc0, 8'ha1, 0, {4'h0, a}, 16'h0004, 0);
                chk("read answer", got, ok ? UCR_ANS_ACK : UCR_ANS_STALL);
                chk("read words", words.size(), ok);
                if (ok) chk("read data", words[0], reg_val(a));
            end
        end
        // statistics: first read returns the tallies, second finds them cleared
        for (int s = 0; s < 2; s++) begin
            bump(40);
            for (int r = 0; r < 2; r++) begin
                req(8'hc0, 8'ha2, 0, s, s ? 16'h0028 : 16'h0020, 0);
                chk("stats answer", got, UCR_ANS_ACK);
                chk("stats words", words.size(), s ? 10 : 8);
                foreach (words[w]) chk("stats word", words[w], r ? 0 : s ? tx_cnt[w] : rx_cnt[w]);
            end
        end
        req(8'hc0, 8'ha2, 0, 16'h0002, 16'h0020, 0);
        chk("stats bad select", got, UCR_ANS_STALL);
        req(8'hc0, 8'h77, 0, 0, 0, 0);
        chk("unknown code", got, UCR_ANS_STALL);
        close_out();
    end
endmodule
`default_nettype wire
